/* verilog/dtc_dual_timer.sv */
// Dual 16-bit timer/counter with special-function register port
`timescale 1ns/1ps

// Behaviour
// R01: Two independent 16-bit up counters, each timer or event counter.
// R02: Timer operation adds one per machine cycle of twelve clocks.
// R03: Counter operation adds one per falling edge on the unit's count input.
// R04: Falling edge recognised over two machine cycles; no duty-cycle limit.
// R05: Count source holds each level at least one machine cycle.
// R06: Run bits (control bit 6 unit 1, bit 4 unit 0) start units.
// R07: Two-bit mode field: 13-bit, 16-bit, 8-bit reload, special.
// R08: 13-bit mode: five low bits in low byte, top three read zero.
// R09: Reload mode counts low byte; overflow copies high byte into it.
// R10: Special mode halts unit 1 and splits unit 0 into two bytes.
// R11: Split: low half uses unit 0 controls, high half unit 1 run/flag.
// R12: Software avoids unit 0 reload mode while unit 1 is 13/16-bit.
// R13: Overflow sets flag; software or interrupt service clears it.
// R14: Select bit 1 picks counter operation, 0 picks timer operation; the code also counts falling edges when the gate bit is set.
// R15: Gate bit with run bit counts falling edges on the count input.
// R16: 13/16-bit modes wrap to zero on overflow; everything resets to zero.
module dtc_dual_timer
    import dtc_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    // Special-function register port
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic [7:0] sfr_wdata_i,
    input  wire logic       sfr_rd_i,
    output logic      [7:0] sfr_rdata_o,
    // Count inputs from digital pins
    input  wire logic       unit0_count_input_i,
    input  wire logic       unit1_count_input_i,
    // Interrupt service acknowledges
    input  wire logic       unit0_irq_ack_i,
    input  wire logic       unit1_irq_ack_i,
    // Flags and baud-rate tick
    output logic            unit0_overflow_flag_o,
    output logic            unit1_overflow_flag_o,
    output logic            unit1_overflow_pulse_o
);

    // State registers
    logic [3:0] div_ff,   nxt_div;
    logic [1:0] syn0_ff,  nxt_syn0;
    logic [1:0] syn1_ff,  nxt_syn1;
    logic [1:0] smp_ff,   nxt_smp;
    logic       run0_ff,  nxt_run0;
    logic       run1_ff,  nxt_run1;
    logic       flag0_ff, nxt_flag0;
    logic       flag1_ff, nxt_flag1;
    logic [7:0] mode_ff,  nxt_mode;
    logic [7:0] lo0_ff,   nxt_lo0;
    logic [7:0] hi0_ff,   nxt_hi0;
    logic [7:0] lo1_ff,   nxt_lo1;
    logic [7:0] hi1_ff,   nxt_hi1;
    logic [7:0] rdata_ff, nxt_rdata;
    logic       pulse_ff, nxt_pulse;

    // Combinational helpers
    logic       mtick;
    logic       fall0;
    logic       fall1;
    logic       en0;
    logic       en1;
    logic       en_hi0;
    logic       ovf0;
    logic       ovf1;
    logic       ovf_hi0;
    logic       split0;
    logic [1:0] m0;
    logic [1:0] m1;
    logic [16:0] st0;
    logic [16:0] st1;

    // One count step: {overflow, high byte, low byte}
    function automatic logic [16:0] dtc_step(input logic [1:0] m,
                                             input logic [7:0] lo,
                                             input logic [7:0] hi);
        logic [16:0] r;
        logic [13:0] s13;
        r   = {1'b0, hi, lo};
        s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        case (m)
            DTC_M_13BIT:  r = {s13[13], s13[12:5], 3'h0, s13[4:0]}; // R08 R16
            DTC_M_16BIT:  r = {1'b0, hi, lo} + 17'h00001;            // R16
            DTC_M_RELOAD: r = (lo == 8'hFF) ? {1'b1, hi, hi}        // R09
                                            : {1'b0, hi, lo + 8'h01};
            default:      r = {1'b0, hi, lo};
        endcase
        return r;
    endfunction : dtc_step

    assign m0     = mode_ff[DTC_MODE_M0_LO +: 2];
    assign m1     = mode_ff[DTC_MODE_M1_LO +: 2];
    assign split0 = (m0 == DTC_M_SPECIAL);
    assign mtick  = (div_ff == DTC_DIV_LAST);

    // Edge seen when the previous machine-cycle sample was high, now low
    assign fall0 = mtick & smp_ff[0] & ~syn0_ff[1]; // R03 R04
    assign fall1 = mtick & smp_ff[1] & ~syn1_ff[1]; // R03 R04

    // Counter operation when select bit or gate bit is set
    assign en0 = run0_ff & mtick                                          // R06
               & ((mode_ff[DTC_MODE_CT0] | mode_ff[DTC_MODE_GATE0]) ? fall0 : 1'b1); // R14 R15
    assign en1 = run1_ff & mtick
               & ((mode_ff[DTC_MODE_CT1] | mode_ff[DTC_MODE_GATE1]) ? fall1 : 1'b1); // R14 R15
    assign en_hi0 = split0 & run1_ff & mtick; // R11

    assign st0     = dtc_step(m0, lo0_ff, hi0_ff);
    assign st1     = dtc_step(m1, lo1_ff, hi1_ff);
    assign ovf0    = en0 & (split0 ? (lo0_ff == 8'hFF) : st0[16]); // R11
    assign ovf_hi0 = en_hi0 & (hi0_ff == 8'hFF);                   // R11
    assign ovf1    = en1 & (m1 != DTC_M_SPECIAL) & st1[16];        // R10

    // Next-state computation for the whole block
    always_comb
    begin
        nxt_div   = mtick ? 4'h0 : div_ff + 4'h1; // R02
        nxt_syn0  = {syn0_ff[0], unit0_count_input_i};
        nxt_syn1  = {syn1_ff[0], unit1_count_input_i};
        // Levels sampled once per machine cycle, so short glitches are missed
        nxt_smp   = mtick ? {syn1_ff[1], syn0_ff[1]} : smp_ff;
        nxt_run0  = run0_ff;
        nxt_run1  = run1_ff;
        nxt_mode  = mode_ff;
        nxt_lo0   = lo0_ff;
        nxt_hi0   = hi0_ff;
        nxt_lo1   = lo1_ff;
        nxt_hi1   = hi1_ff;
        nxt_flag0 = flag0_ff;
        nxt_flag1 = flag1_ff;
        nxt_pulse = ovf1;
        nxt_rdata = 8'h00;

        // Unit 0 counting, whole or split
        if (split0)
        begin
            if (en0)
                nxt_lo0 = lo0_ff + 8'h01; // R10 R11
            if (en_hi0)
                nxt_hi0 = hi0_ff + 8'h01; // R11
        end
        else if (en0)
        begin
            nxt_lo0 = st0[7:0]; // R01 R07
            nxt_hi0 = st0[15:8];
        end

        // Unit 1 stands still in special mode
        if (en1 && m1 != DTC_M_SPECIAL) // R10
        begin
            nxt_lo1 = st1[7:0]; // R01 R07
            nxt_hi1 = st1[15:8];
        end

        // Software access; a register write overrides the count step
        if (sfr_wr_i)
        begin
            unique case (sfr_addr_i)
                DTC_ADDR_CTRL:
                begin
                    nxt_run0  = sfr_wdata_i[DTC_CTRL_RUN0]; // R06
                    nxt_run1  = sfr_wdata_i[DTC_CTRL_RUN1]; // R06
                    nxt_flag0 = sfr_wdata_i[DTC_CTRL_FLAG0];
                    nxt_flag1 = sfr_wdata_i[DTC_CTRL_FLAG1];
                end
                DTC_ADDR_MODE: nxt_mode = sfr_wdata_i; // R07
                DTC_ADDR_LO0:  nxt_lo0  = sfr_wdata_i;
                DTC_ADDR_LO1:  nxt_lo1  = sfr_wdata_i;
                DTC_ADDR_HI0:  nxt_hi0  = sfr_wdata_i;
                DTC_ADDR_HI1:  nxt_hi1  = sfr_wdata_i;
                default:       nxt_mode = mode_ff;
            endcase
        end

        // Service clears; hardware set wins over any clear
        if (unit0_irq_ack_i)
            nxt_flag0 = 1'b0; // R13
        if (unit1_irq_ack_i)
            nxt_flag1 = 1'b0; // R13
        if (ovf0)
            nxt_flag0 = 1'b1; // R13
        if (split0 ? ovf_hi0 : ovf1)
            nxt_flag1 = 1'b1; // R11 R13

        // Registered read data; unmapped addresses read zero
        if (sfr_rd_i)
        begin
            unique case (sfr_addr_i)
                DTC_ADDR_CTRL: nxt_rdata = {flag1_ff, run1_ff, flag0_ff, run0_ff, 4'h0};
                DTC_ADDR_MODE: nxt_rdata = mode_ff;
                DTC_ADDR_LO0:  nxt_rdata = (m0 == DTC_M_13BIT) ? {3'h0, lo0_ff[4:0]} // R08
                                                               : lo0_ff;
                DTC_ADDR_LO1:  nxt_rdata = (m1 == DTC_M_13BIT) ? {3'h0, lo1_ff[4:0]} // R08
                                                               : lo1_ff;
                DTC_ADDR_HI0:  nxt_rdata = hi0_ff;
                DTC_ADDR_HI1:  nxt_rdata = hi1_ff;
                default:       nxt_rdata = 8'h00;
            endcase
        end
    end

    // State registers; all bytes and controls clear on reset
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            div_ff   <= 4'h0;
            syn0_ff  <= 2'h0;
            syn1_ff  <= 2'h0;
            smp_ff   <= 2'h0;
            run0_ff  <= 1'b0;
            run1_ff  <= 1'b0;
            flag0_ff <= 1'b0;
            flag1_ff <= 1'b0;
            mode_ff  <= DTC_RST_BYTE; // R16
            lo0_ff   <= DTC_RST_BYTE;
            hi0_ff   <= DTC_RST_BYTE;
            lo1_ff   <= DTC_RST_BYTE;
            hi1_ff   <= DTC_RST_BYTE;
            rdata_ff <= 8'h00;
            pulse_ff <= 1'b0;
        end
        else
        begin
            div_ff   <= nxt_div;
            syn0_ff  <= nxt_syn0;
            syn1_ff  <= nxt_syn1;
            smp_ff   <= nxt_smp;
            run0_ff  <= nxt_run0;
            run1_ff  <= nxt_run1;
            flag0_ff <= nxt_flag0;
            flag1_ff <= nxt_flag1;
            mode_ff  <= nxt_mode;
            lo0_ff   <= nxt_lo0;
            hi0_ff   <= nxt_hi0;
            lo1_ff   <= nxt_lo1;
            hi1_ff   <= nxt_hi1;
            rdata_ff <= nxt_rdata;
            pulse_ff <= nxt_pulse;
        end
    end

    // Outputs straight from flops
    assign sfr_rdata_o            = rdata_ff;
    assign unit0_overflow_flag_o  = flag0_ff;
    assign unit1_overflow_flag_o  = flag1_ff;
    assign unit1_overflow_pulse_o = pulse_ff;

    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    logic wr_u0;
    logic wr_u1;
    assign wr_u0 = sfr_wr_i & (sfr_addr_i == DTC_ADDR_LO0 || sfr_addr_i == DTC_ADDR_HI0);
    assign wr_u1 = sfr_wr_i & (sfr_addr_i == DTC_ADDR_LO1 || sfr_addr_i == DTC_ADDR_HI1);

    sequence quiet_gap_s;
        (!mtick)[*8] ##1 !mtick ##1 !mtick ##1 !mtick;
    endsequence

    mcyc_period_a: assert property (mtick |=> quiet_gap_s ##1 mtick) // R02
        else $error("machine cycle tick not every 12 clocks");
    timer_step_a: assert property (mtick && run0_ff && m0 == DTC_M_16BIT // R01
        && !mode_ff[DTC_MODE_CT0] && !mode_ff[DTC_MODE_GATE0] && !wr_u0
        |=> {hi0_ff, lo0_ff} == $past({hi0_ff, lo0_ff}) + 16'h0001)
        else $error("unit 0 timer did not advance by one");
    stop_hold_a: assert property (!run0_ff && !run1_ff && !wr_u0 // R06
        |=> $stable({hi0_ff, lo0_ff}))
        else $error("stopped unit 0 changed");
    no_edge_hold_a: assert property (mtick && mode_ff[DTC_MODE_CT1] && !fall1 // R03
        && !wr_u1 |=> $stable({hi1_ff, lo1_ff}))
        else $error("unit 1 counted without a falling edge");
    reload_copy_a: assert property (en0 && m0 == DTC_M_RELOAD && lo0_ff == 8'hFF // R09
        && !wr_u0 |=> lo0_ff == hi0_ff && flag0_ff)
        else $error("reload mode did not copy high byte");
    low_mask_a: assert property (sfr_rd_i && sfr_addr_i == DTC_ADDR_LO0 // R08
        && m0 == DTC_M_13BIT |=> sfr_rdata_o[7:5] == 3'h0)
        else $error("13-bit low byte top bits not zero");
    flag_set_a: assert property (ovf0 |=> flag0_ff ##1 1'b1) // R13
        else $error("overflow did not raise flag");
    halt_unit1_a: assert property (m1 == DTC_M_SPECIAL && !wr_u1 // R10
        |=> $stable({hi1_ff, lo1_ff}))
        else $error("unit 1 moved in special mode");

    split_high_a: assert property (split0 && run1_ff && mtick && hi0_ff == 8'hFF // R11
        && !wr_u0 |=> hi0_ff == 8'h00 && flag1_ff)
        else $error("split high half overflow wrong");

    edge_latency_a: assert property (mtick && run1_ff && mode_ff[DTC_MODE_CT1] // R04
        && m1 == DTC_M_16BIT && !wr_u1 && smp_ff[1] && !syn1_ff[1]
        |=> {hi1_ff, lo1_ff} == $past({hi1_ff, lo1_ff}) + 16'h0001)
        else $error("falling edge not counted");

endmodule : dtc_dual_timer

/* verilog/dtc_pkg.sv */
// Register map, field layout and timing constants of the dual timer/counter
package dtc_pkg;

    // Register addresses on the special-function port
    localparam logic [7:0] DTC_ADDR_CTRL = 8'h88;
    localparam logic [7:0] DTC_ADDR_MODE = 8'h89;
    localparam logic [7:0] DTC_ADDR_LO0  = 8'h8A;
    localparam logic [7:0] DTC_ADDR_LO1  = 8'h8B;
    localparam logic [7:0] DTC_ADDR_HI0  = 8'h8C;
    localparam logic [7:0] DTC_ADDR_HI1  = 8'h8D;

    // Control/flag register bit positions
    localparam int DTC_CTRL_FLAG1 = 7;
    localparam int DTC_CTRL_RUN1  = 6;
    localparam int DTC_CTRL_FLAG0 = 5;
    localparam int DTC_CTRL_RUN0  = 4;

    // Mode register: unit 1 in the upper nibble, unit 0 in the lower
    localparam int DTC_MODE_GATE1 = 7;
    localparam int DTC_MODE_CT1   = 6;
    localparam int DTC_MODE_M1_LO = 4;
    localparam int DTC_MODE_GATE0 = 3;
    localparam int DTC_MODE_CT0   = 2;
    localparam int DTC_MODE_M0_LO = 0;

    // Count mode field encodings
    localparam logic [1:0] DTC_M_13BIT = 2'h0;
    localparam logic [1:0] DTC_M_16BIT = 2'h1;
    localparam logic [1:0] DTC_M_RELOAD = 2'h2;
    localparam logic [1:0] DTC_M_SPECIAL = 2'h3;

    // Reset values
    localparam logic [7:0] DTC_RST_BYTE = 8'h00;

    // Machine cycle length in clocks
    localparam int         DTC_MCYC_CLKS = 12;
    localparam logic [3:0] DTC_DIV_LAST  = 4'(DTC_MCYC_CLKS - 1);

endpackage : dtc_pkg

/* test/dtc_pin_source.sv */
// Count-pin source model driving falling edges onto the count inputs
`timescale 1ns/1ps
module dtc_pin_source
#(
    parameter int PULSES = 3
)
(
    // Clock and request
    input  wire logic mclk_i,
    input  wire logic go_i,
    // Pin side
    output logic      pin_o,
    output logic      busy_o
);
    // Each level lasts 24 clocks so it always spans a full machine cycle
    initial
    begin
        pin_o = 1'b1;
        busy_o = 1'b0;
        forever
        begin
            do @(posedge mclk_i); while (go_i !== 1'b1);
            busy_o <= 1'b1;
            repeat (PULSES)
            begin
                pin_o <= 1'b0;
                repeat (24) @(posedge mclk_i);
                pin_o <= 1'b1;
                repeat (24) @(posedge mclk_i);
            end
            busy_o <= 1'b0;
        end
    end
endmodule : dtc_pin_source

/* test/dual_timer_counter_bench.sv */
// Self-checking bench for the dual timer/counter
`timescale 1ns/1ps
module dual_timer_counter_bench;
    import dtc_pkg::*;
    logic       mclk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       ack0 = 1'b0;
    logic       ack1 = 1'b0;
    logic       go = 1'b0;
    logic [7:0] rdata;
    logic       pin, busy, flag0, flag1, tick1;
    int         error_cnt = 0;
    int         checks_done = 0;
    logic [7:0] pulse_cnt = 8'h00;

    always #20 mclk_i = ~mclk_i;

    // Baud pulses counted mid-cycle, away from the edge that launches them
    always @(negedge mclk_i)
        if (tick1 === 1'b1)
            pulse_cnt <= pulse_cnt + 8'h01;

    dtc_dual_timer u_dtc_dual_timer (.mclk_i(mclk_i), .rst_i(rst_i),
        .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_wdata_i(wdata), .sfr_rd_i(rd),
        .sfr_rdata_o(rdata), .unit0_count_input_i(pin), .unit1_count_input_i(pin),
        .unit0_irq_ack_i(ack0), .unit1_irq_ack_i(ack1), .unit0_overflow_flag_o(flag0),
        .unit1_overflow_flag_o(flag1), .unit1_overflow_pulse_o(tick1));

    dtc_pin_source #(.PULSES(3)) u_dtc_pin_source (.mclk_i(mclk_i), .go_i(go),
        .pin_o(pin), .busy_o(busy));

    // Verdict and end of run
    task automatic end_of_test();
        if (error_cnt == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    // Compare one byte, four-state exact
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // One-cycle write strobe
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
    endtask : wr_reg

    // Read strobe, data lands one cycle later
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        #1;
        check(rdata, e);
    endtask : rd_chk

    // Bounded wait for an overflow flag
    task automatic wait_flag(input bit u);
        int k;
        for (k = 0; k < 40; k++)
        begin
            @(posedge mclk_i);
            #1;
            if ((u ? flag1 : flag0) === 1'b1)
                break;
        end
        check({7'h00, u ? flag1 : flag0}, 8'h01);
    endtask : wait_flag

    // Interrupt service pulse clears the flag
    task automatic ack(input bit u);
        @(posedge mclk_i);
        ack0 <= !u;
        ack1 <= u;
        @(posedge mclk_i);
        ack0 <= 1'b0;
        ack1 <= 1'b0;
        #1;
        check({6'h00, flag1, flag0}, 8'h00);
    endtask : ack

    // All registers start at zero, unmapped place reads zero
    task automatic s_reset();
        int i;
        for (i = 0; i < 7; i++)
            rd_chk(8'h88 + 8'(i), 8'h00);
    endtask : s_reset

    // 16-bit overflow wraps to zero and raises flag 0
    task automatic s_wrap16();
        wr_reg(DTC_ADDR_MODE, 8'h01);
        wr_reg(DTC_ADDR_LO0, 8'hFF);
        wr_reg(DTC_ADDR_HI0, 8'hFF);
        wr_reg(DTC_ADDR_CTRL, 8'h10);
        wait_flag(1'b0);
        rd_chk(DTC_ADDR_LO0, 8'h00);
        rd_chk(DTC_ADDR_HI0, 8'h00);
        // Stop the unit so later scenarios start from a known count
        wr_reg(DTC_ADDR_CTRL, 8'h20);
        rd_chk(DTC_ADDR_CTRL, 8'h20);
        ack(1'b0);
    endtask : s_wrap16

    // Run exactly 120 clocks: ten machine cycles
    task automatic s_rate();
        wr_reg(DTC_ADDR_LO0, 8'h00);
        wr_reg(DTC_ADDR_CTRL, 8'h10);
        repeat (118) @(posedge mclk_i);
        wr_reg(DTC_ADDR_CTRL, 8'h00);
        rd_chk(DTC_ADDR_LO0, 8'h0A);
    endtask : s_rate

    // 13-bit: masked low byte and carry out of bit 4
    task automatic s_13bit();
        wr_reg(DTC_ADDR_MODE, 8'h00);
        wr_reg(DTC_ADDR_HI0, 8'h00);
        wr_reg(DTC_ADDR_LO0, 8'hFF);
        rd_chk(DTC_ADDR_LO0, 8'h1F);
        wr_reg(DTC_ADDR_CTRL, 8'h10);
        repeat (10) @(posedge mclk_i);
        wr_reg(DTC_ADDR_CTRL, 8'h00);
        rd_chk(DTC_ADDR_LO0, 8'h00);
        rd_chk(DTC_ADDR_HI0, 8'h01);
    endtask : s_13bit

    // Both units auto-reload from their high bytes on the same tick
    task automatic s_reload();
        wr_reg(DTC_ADDR_MODE, 8'h22);
        wr_reg(DTC_ADDR_HI1, 8'hF0);
        wr_reg(DTC_ADDR_LO1, 8'hFF);
        wr_reg(DTC_ADDR_HI0, 8'hA5);
        wr_reg(DTC_ADDR_LO0, 8'hFF);
        wr_reg(DTC_ADDR_CTRL, 8'h50);
        wait_flag(1'b1);
        wait_flag(1'b0);
        rd_chk(DTC_ADDR_LO1, 8'hF0);
        rd_chk(DTC_ADDR_HI1, 8'hF0);
        rd_chk(DTC_ADDR_LO0, 8'hA5);
        // Stop both before the next tick; software clears flag 0, keeps flag 1
        wr_reg(DTC_ADDR_CTRL, 8'h80);
        check(pulse_cnt, 8'h01);
        ack(1'b1);
    endtask : s_reload

    // Falling edges counted by both units, by select bit and by gate bit
    task automatic s_count(input logic [7:0] mode);
        int k;
        wr_reg(DTC_ADDR_MODE, mode);
        wr_reg(DTC_ADDR_LO0, 8'h00);
        wr_reg(DTC_ADDR_HI0, 8'h00);
        wr_reg(DTC_ADDR_LO1, 8'h00);
        wr_reg(DTC_ADDR_HI1, 8'h00);
        wr_reg(DTC_ADDR_CTRL, 8'h50);
        go <= 1'b1;
        @(posedge mclk_i);
        go <= 1'b0;
        repeat (2) @(posedge mclk_i);
        for (k = 0; k < 400 && busy === 1'b1; k++)
            @(posedge mclk_i);
        repeat (48) @(posedge mclk_i);
        wr_reg(DTC_ADDR_CTRL, 8'h00);
        rd_chk(DTC_ADDR_LO0, 8'h03);
        rd_chk(DTC_ADDR_LO1, 8'h03);
    endtask : s_count

    // Split unit 0, unit 1 halted; both halves overflow together
    task automatic s_split();
        wr_reg(DTC_ADDR_MODE, 8'h33);
        wr_reg(DTC_ADDR_LO1, 8'h05);
        wr_reg(DTC_ADDR_LO0, 8'hFF);
        wr_reg(DTC_ADDR_HI0, 8'hFF);
        wr_reg(DTC_ADDR_CTRL, 8'h50);
        wait_flag(1'b0);
        wait_flag(1'b1);
        rd_chk(DTC_ADDR_LO0, 8'h00);
        rd_chk(DTC_ADDR_HI0, 8'h00);
        rd_chk(DTC_ADDR_LO1, 8'h05);
        check(pulse_cnt, 8'h01);
    endtask : s_split

    // Main sequence after eight reset cycles
    initial
    begin
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
        s_reset();
        s_wrap16();
        s_rate();
        s_13bit();
        s_reload();
        s_count(8'h55);
        s_count(8'h99);
        s_split();
        end_of_test();
    end

    // Watchdog well beyond the roughly 700 cycles the tests need
    initial
    begin
        repeat (6000) @(posedge mclk_i);
        error_cnt++;
        end_of_test();
    end
endmodule : dual_timer_counter_bench
